// [pkg/lsft_if.sv]
// link events and algorithm requests shared by the front end modules
`timescale 1ns/1ns
interface lsft_if import lsft_pkg::*; #(
  parameter int AW = 24
);
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic cs_start;
  logic si;
  logic pup_sleep;
  logic boot_octal;
  logic go;
  lsft_op_t op;
  logic [AW-1:0] addr;
  logic [7:0] data;
  logic busy;
  logic fail;

  modport sync_mp (output sck_rise, sck_fall, cs_act, cs_start, si, pup_sleep, boot_octal);
  modport algo_mp (input go, op, addr, data, output busy, fail);
  modport core_mp (input sck_rise, sck_fall, cs_act, cs_start, si, pup_sleep, boot_octal,
                   input busy, fail, output go, op, addr, data);
endinterface : lsft_if

// [pkg/lsft_params.svh]
// constants of the serial flash transaction front end
`ifndef LSFT_PARAMS_SVH
`define LSFT_PARAMS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define LSFT_ADDR_BYTES 3
`define LSFT_SECT_W 4
`define LSFT_LAT_W 4
`define LSFT_LAT_DEF 4'h8

// ----------------------------------------
// command codes
// ----------------------------------------
`define LSFT_CMD_READ 8'h03
`define LSFT_CMD_FREAD 8'h0B
`define LSFT_CMD_PGM 8'h02
`define LSFT_CMD_ERASE 8'hD8
`define LSFT_CMD_RDSR 8'h05
`define LSFT_CMD_RDECC 8'h19
`define LSFT_CMD_WRLAT 8'h71
`define LSFT_CMD_LOCK 8'h36
`define LSFT_CMD_ULOCK 8'h39
`define LSFT_CMD_SLEEP 8'hB9
`define LSFT_CMD_WAKE 8'hAB

// ----------------------------------------
// status byte fields
// ----------------------------------------
`define LSFT_SR_BUSY 0
`define LSFT_SR_FAIL 1

// ----------------------------------------
// timing
// ----------------------------------------
`define LSFT_CLK_NS 40
`define LSFT_PGM_NS 2000
`define LSFT_ERS_NS 100000
`define LSFT_POR_CYC 2'h3

`endif

// [pkg/lsft_pkg.sv]
// types of the serial flash transaction front end
package lsft_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_LAT = 7'h08,
    ST_DIN = 7'h10,
    ST_DOUT = 7'h20,
    ST_IGNORE = 7'h40
  } lsft_phase_t;

  typedef enum logic [1:0] {
    AL_IDLE = 2'h1,
    AL_RUN = 2'h2
  } lsft_algo_st_t;

  typedef enum logic [1:0] {
    OP_PGM = 2'h0,
    OP_ERASE = 2'h1,
    OP_LOCK = 2'h2,
    OP_ULOCK = 2'h3
  } lsft_op_t;

  typedef enum logic [1:0] {
    SRC_ARRAY = 2'h0,
    SRC_STATUS = 2'h1,
    SRC_ECC = 2'h2
  } lsft_src_t;

endpackage : lsft_pkg

// [src/lsft_algo.sv]
// embedded algorithm controller: timed program / erase with sector locks
`timescale 1ns/1ns
`include "lsft_params.svh"
module lsft_algo import lsft_pkg::*; #(
  parameter int AW = 24,
  parameter int SECT_W = `LSFT_SECT_W
) (
  input wire logic i_ref_clk, // core clock
  input wire logic i_rst, // async reset, high
  lsft_if.algo_mp ifc, // requests from the core
  output logic o_pgm_stb, // program strobe to array
  output logic o_ers_stb, // erase strobe to array
  output logic [AW-1:0] o_wr_addr, // array target address
  output logic [7:0] o_wr_data // program data
);
  localparam int PGM_CYC = (`LSFT_PGM_NS + `LSFT_CLK_NS - 1) / `LSFT_CLK_NS;
  localparam int ERS_CYC = (`LSFT_ERS_NS + `LSFT_CLK_NS - 1) / `LSFT_CLK_NS;
  localparam int TW = $clog2(ERS_CYC + 1);

  lsft_algo_st_t st;
  logic [TW-1:0] timer;
  logic [(1 << SECT_W)-1:0] lock;
  logic [SECT_W-1:0] sect;

  assign sect = ifc.addr[AW-1 -: SECT_W];
  assign ifc.busy = (st == AL_RUN);

  // ----------------------------------------
  // algorithm sequencing
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st <= AL_IDLE;
      timer <= '0;
      ifc.fail <= 1'b0;
      o_pgm_stb <= 1'b0;
      o_ers_stb <= 1'b0;
      o_wr_addr <= '0;
      o_wr_data <= 8'h00;
    end
    else
    begin
      o_pgm_stb <= 1'b0;
      o_ers_stb <= 1'b0;
      unique case (st)
        AL_IDLE:
        begin
          if (ifc.go && (ifc.op == OP_PGM || ifc.op == OP_ERASE))
          begin
            // a locked sector fails at once and never starts
            if (lock[sect])
              ifc.fail <= 1'b1;
            else
            begin
              ifc.fail <= 1'b0;
              st <= AL_RUN;
              o_wr_addr <= ifc.addr;
              o_wr_data <= ifc.data;
              o_pgm_stb <= (ifc.op == OP_PGM);
              o_ers_stb <= (ifc.op == OP_ERASE);
              timer <= (ifc.op == OP_PGM) ? TW'(PGM_CYC - 1) : TW'(ERS_CYC - 1);
            end
          end
        end
        AL_RUN:
        begin
          // runs to the end whatever the select pin does
          if (timer == '0)
            st <= AL_IDLE;
          else
            timer <= timer - 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // volatile sector locks, open after reset
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      lock <= '0;
    else if (ifc.go && st == AL_IDLE && ifc.op == OP_LOCK)
      lock[sect] <= 1'b1;
    else if (ifc.go && st == AL_IDLE && ifc.op == OP_ULOCK)
      lock[sect] <= 1'b0;
  end
endmodule : lsft_algo

// [src/lsft_sync.sv]
// pin synchronisers and serial clock / select edge finder
`timescale 1ns/1ns
module lsft_sync (
  input wire logic i_ref_clk, // core clock
  input wire logic i_rst, // async reset, high
  input wire logic i_cs_n, // select pin, low active
  input wire logic i_sck, // serial clock pin
  input wire logic i_si, // serial input pin
  input wire logic i_pup_sleep, // strap: power up asleep
  input wire logic i_boot_octal, // strap: boot octal
  lsft_if.sync_mp ifc // events to the core
);
  logic [4:0] meta;
  logic [4:0] sync;
  logic sck_d;
  logic cs_d;

  // ----------------------------------------
  // two-stage synchronisers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= 5'h01;
      sync <= 5'h01;
    end
    else
    begin
      meta <= {i_boot_octal, i_pup_sleep, i_si, i_sck, i_cs_n};
      sync <= meta;
    end
  end

  // ----------------------------------------
  // edge history, taken from the second stage only
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sck_d <= sync[1];
      cs_d <= sync[0];
    end
  end

  assign ifc.sck_rise = sync[1] & ~sck_d;
  assign ifc.sck_fall = ~sync[1] & sck_d;
  assign ifc.cs_act = ~sync[0];
  assign ifc.cs_start = cs_d & ~sync[0];
  assign ifc.si = sync[2];
  assign ifc.pup_sleep = sync[3];
  assign ifc.boot_octal = sync[4];
endmodule : lsft_sync

// [src/lsft_top.sv]
// single-bit serial flash transaction front end, device side
`timescale 1ns/1ns
`include "lsft_params.svh"

module lsft_top import lsft_pkg::*; #(
  parameter int ADDR_BYTES = `LSFT_ADDR_BYTES,
  parameter int SECT_W = `LSFT_SECT_W
) (
  input wire logic i_ref_clk, // core clock, 25 MHz
  input wire logic i_rst, // async reset, high
  input wire logic i_cs_n, // chip select, low active
  input wire logic i_sck, // serial clock from host
  input wire logic i_si, // serial input, line zero
  output logic o_so, // serial output, line one
  output logic o_so_oe_n, // low while line one is driven
  output logic [5:0] o_dq_hi_oe_n, // enables of lines 7..2, never low
  input wire logic i_pup_sleep, // strap: start in deep sleep
  input wire logic i_boot_octal, // strap: boot in octal mode
  output logic o_octal_mode, // octal boot taken, serial port idle
  output logic [8*ADDR_BYTES-1:0] o_rd_addr, // array read address
  input wire logic [7:0] i_rd_data, // array read byte
  output logic o_pgm_stb, // program strobe to array
  output logic o_ers_stb, // erase strobe to array
  output logic [8*ADDR_BYTES-1:0] o_wr_addr, // program / erase address
  output logic [7:0] o_wr_data, // program data
  input wire logic i_ecc_err, // array corrected error pulse
  input wire logic [8*ADDR_BYTES-1:0] i_ecc_addr, // address of that error
  output logic [7:0] o_ecc_count, // error detection counter
  output logic [8*ADDR_BYTES-1:0] o_ecc_trap, // last error address
  output logic o_ecc_seen, // ecc status flag
  output logic o_deep_sleep, // deep sleep state
  output logic o_busy, // algorithm in progress
  output logic o_standby // controller in standby
);
  localparam int AW = 8 * ADDR_BYTES;
  localparam int ABW = $clog2(ADDR_BYTES + 1);

  lsft_if #(.AW(AW)) ifc ();

  lsft_phase_t state;
  lsft_src_t src;
  logic [2:0] bcnt;
  logic [2:0] ocnt;
  logic [6:0] sh;
  logic [7:0] cmd;
  logic [7:0] byte_in;
  logic [7:0] obyte;
  logic [ABW-1:0] acnt;
  logic [AW-1:0] addr;
  logic [`LSFT_LAT_W-1:0] lat;
  logic [`LSFT_LAT_W-1:0] lcnt;
  logic [1:0] por_cnt;
  logic por_done;
  logic octal;
  logic sleep;
  logic byte_done;
  logic first_out;
  logic [7:0] pick;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  lsft_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_cs_n(i_cs_n),
    .i_sck(i_sck),
    .i_si(i_si),
    .i_pup_sleep(i_pup_sleep),
    .i_boot_octal(i_boot_octal),
    .ifc(ifc.sync_mp)
  );

  lsft_algo #(.AW(AW), .SECT_W(SECT_W)) u_algo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .ifc(ifc.algo_mp),
    .o_pgm_stb(o_pgm_stb),
    .o_ers_stb(o_ers_stb),
    .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data)
  );

  // one function serves every byte source of the output phase
  function automatic logic [7:0] lsft_pick(input lsft_src_t s, input logic [7:0] rd,
                                           input logic busy, input logic fail,
                                           input logic [7:0] cnt);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      SRC_ARRAY: v = rd;
      SRC_STATUS:
      begin
        v[`LSFT_SR_BUSY] = busy;
        v[`LSFT_SR_FAIL] = fail;
      end
      SRC_ECC: v = cnt;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : lsft_pick

  // a byte closes on its eighth rising edge, msb arrived first
  assign byte_in = {sh, ifc.si};
  assign byte_done = ifc.sck_rise && (bcnt == 3'h7);
  assign first_out = (ocnt == 3'h0);
  assign pick = lsft_pick(src, i_rd_data, ifc.busy, ifc.fail, o_ecc_count);
  assign o_rd_addr = addr;
  assign o_busy = ifc.busy;
  assign o_deep_sleep = sleep;
  assign o_octal_mode = octal;
  // upper lines are never driven in single-bit mode
  assign o_dq_hi_oe_n = 6'h3F;

  // ----------------------------------------
  // power-on: straps are caught after the synchronisers settle
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      por_cnt <= 2'h0;
      por_done <= 1'b0;
      octal <= 1'b0;
    end
    else if (!por_done)
    begin
      por_cnt <= por_cnt + 2'h1;
      if (por_cnt == `LSFT_POR_CYC)
      begin
        por_done <= 1'b1;
        octal <= ifc.boot_octal;
      end
    end
  end

  // ----------------------------------------
  // transaction sequencer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
      src <= SRC_ARRAY;
      bcnt <= 3'h0;
      sh <= 7'h00;
      cmd <= 8'h00;
      acnt <= '0;
      addr <= '0;
      lcnt <= '0;
      lat <= `LSFT_LAT_DEF;
      sleep <= 1'b0;
      ifc.go <= 1'b0;
      ifc.op <= OP_PGM;
      ifc.addr <= '0;
      ifc.data <= 8'h00;
    end
    else
    begin
      ifc.go <= 1'b0;
      if (!por_done)
      begin
        // select held high through power-on starts asleep when strapped
        if (por_cnt == `LSFT_POR_CYC)
          sleep <= ifc.pup_sleep && !ifc.cs_act;
      end
      else if (octal || !ifc.cs_act)
        state <= ST_IDLE;
      else if (ifc.cs_start)
      begin
        state <= ST_CMD;
        bcnt <= 3'h0;
        acnt <= '0;
      end
      else if (ifc.sck_rise)
      begin
        // everything from the host is taken from line zero on rising serial clock edges
        sh <= byte_in[6:0];
        bcnt <= bcnt + 3'h1;
        unique case (state)
          ST_CMD:
          begin
            if (byte_done)
            begin
              cmd <= byte_in;
              state <= ST_IGNORE;
              if (sleep)
              begin
                if (byte_in == `LSFT_CMD_WAKE)
                  sleep <= 1'b0;
              end
              else if (ifc.busy && byte_in != `LSFT_CMD_RDSR)
                state <= ST_IGNORE;
              else
              begin
                unique case (byte_in)
                  `LSFT_CMD_READ, `LSFT_CMD_FREAD, `LSFT_CMD_PGM,
                  `LSFT_CMD_ERASE, `LSFT_CMD_LOCK, `LSFT_CMD_ULOCK:
                    state <= ST_ADDR;
                  `LSFT_CMD_RDSR:
                  begin
                    src <= SRC_STATUS;
                    state <= ST_DOUT;
                  end
                  `LSFT_CMD_RDECC:
                  begin
                    src <= SRC_ECC;
                    state <= ST_DOUT;
                  end
                  `LSFT_CMD_WRLAT: state <= ST_DIN;
                  // busy is already excluded here, so this is standby
                  `LSFT_CMD_SLEEP: sleep <= 1'b1;
                  default: state <= ST_IGNORE;
                endcase
              end
            end
          end
          ST_ADDR:
          begin
            if (byte_done)
            begin
              addr <= {addr[AW-9:0], byte_in};
              acnt <= acnt + 1'b1;
              if (acnt == ABW'(ADDR_BYTES - 1))
              begin
                src <= SRC_ARRAY;
                lcnt <= '0;
                ifc.addr <= {addr[AW-9:0], byte_in};
                unique case (cmd)
                  `LSFT_CMD_READ: state <= ST_DOUT;
                  `LSFT_CMD_FREAD: state <= (lat == '0) ? ST_DOUT : ST_LAT;
                  `LSFT_CMD_PGM: state <= ST_DIN;
                  `LSFT_CMD_ERASE:
                  begin
                    ifc.op <= OP_ERASE;
                    ifc.go <= 1'b1;
                    state <= ST_IGNORE;
                  end
                  `LSFT_CMD_LOCK, `LSFT_CMD_ULOCK:
                  begin
                    ifc.op <= (cmd == `LSFT_CMD_LOCK) ? OP_LOCK : OP_ULOCK;
                    ifc.go <= 1'b1;
                    state <= ST_IGNORE;
                  end
                  default: state <= ST_IGNORE;
                endcase
              end
            end
          end
          ST_LAT:
          begin
            lcnt <= lcnt + 1'b1;
            if (lcnt == lat - 1'b1)
              state <= ST_DOUT;
          end
          ST_DIN:
          begin
            if (byte_done)
            begin
              state <= ST_IGNORE;
              if (cmd == `LSFT_CMD_WRLAT)
                lat <= byte_in[`LSFT_LAT_W-1:0];
              else
              begin
                ifc.op <= OP_PGM;
                ifc.data <= byte_in;
                ifc.go <= 1'b1;
              end
            end
          end
          ST_IDLE, ST_DOUT, ST_IGNORE:
            state <= state;
        endcase
      end
      else if (ifc.sck_fall && state == ST_DOUT && ocnt == 3'h7)
        addr <= addr + 1'b1;
    end
  end

  // ----------------------------------------
  // serial output: bits move on falling edges so they stand across the next rise
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
      ocnt <= 3'h0;
      obyte <= 8'h00;
    end
    else if (state != ST_DOUT)
    begin
      o_so <= 1'b0;
      o_so_oe_n <= 1'b1;
      ocnt <= 3'h0;
    end
    else if (ifc.sck_fall)
    begin
      o_so_oe_n <= 1'b0;
      ocnt <= ocnt + 3'h1;
      if (first_out)
      begin
        // array data settled: the address moved a whole bit time earlier, half a bit time for the first byte of a plain read or a zero-latency fast read
        obyte <= pick;
        o_so <= pick[7];
      end
      else
        o_so <= obyte[3'h7 - ocnt];
    end
  end

  // ----------------------------------------
  // ecc bookkeeping, wiped on leaving deep sleep
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ecc_count <= 8'h00;
      o_ecc_trap <= '0;
      o_ecc_seen <= 1'b0;
    end
    else if (sleep && byte_done && state == ST_CMD && byte_in == `LSFT_CMD_WAKE
             && ifc.cs_act && !ifc.cs_start && por_done && !octal)
    begin
      o_ecc_count <= 8'h00;
      o_ecc_trap <= '0;
      o_ecc_seen <= 1'b0;
    end
    else if (i_ecc_err)
    begin
      o_ecc_seen <= 1'b1;
      o_ecc_trap <= i_ecc_addr;
      if (o_ecc_count != 8'hFF)
        o_ecc_count <= o_ecc_count + 8'h01;
    end
  end

  // ----------------------------------------
  // standby: no command in flight, no algorithm, awake
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_standby <= 1'b0;
    else
      o_standby <= por_done && !sleep && !ifc.busy && !ifc.cs_act;
  end
endmodule : lsft_top

// [testbench/lsft_host_model.sv]
// host controller model driving the serial link
`timescale 1ns/1ns
module lsft_host_model (
  output logic o_cs_n, // select to device
  output logic o_sck, // serial clock
  output logic o_si, // line zero
  input wire logic i_so // line one
);
  localparam int HALF = 160;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  task open_tx;
    o_cs_n = 1'b0;
    #HALF;
  endtask : open_tx
  // line one is read mid high phase, long after the device moved it on the fall
  task shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < n; i++)
    begin
      o_si = tx[7 - (i % 8)];
      #HALF;
      o_sck = 1'b1;
      #(HALF / 2);
      rx = {rx[6:0], i_so};
      #(HALF / 2);
      o_sck = 1'b0;
    end
  endtask : shift
  task close_tx;
    #HALF;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #(2 * HALF);
  endtask : close_tx
endmodule : lsft_host_model

// [testbench/lsft_top_bench.sv]
// self-checking bench of the serial flash front end
`timescale 1ns/1ns
module lsft_top_bench import lsft_pkg::*;;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ecc_err = 1'b0;
  logic strap = 1'b0;
  logic [23:0] i_ecc_addr = 24'h000000;
  logic i_cs_n, i_sck, i_si, o_so, o_so_oe_n, o_octal_mode, o_pgm_stb, o_ers_stb;
  logic o_ecc_seen, o_deep_sleep, o_busy, o_standby, drove;
  logic [5:0] o_dq_hi_oe_n;
  logic [23:0] o_rd_addr, o_wr_addr, o_ecc_trap, a, b;
  logic [7:0] o_wr_data, o_ecc_count, i_rd_data, rx, d;
  int err_total = 0, checked = 0, cyc = 0, pgm_n = 0, ers_n = 0, lat;
  always #20 i_ref_clk = ~i_ref_clk;
  function automatic logic [7:0] arr(input logic [23:0] ad);
    return ad[7:0] ^ ad[23:16] ^ 8'h5A;
  endfunction : arr
  assign i_rd_data = arr(o_rd_addr);
  lsft_host_model host_u (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si), .i_so(o_so));
  lsft_top dut_u (.i_ref_clk, .i_rst, .i_cs_n, .i_sck, .i_si, .o_so, .o_so_oe_n,
    .o_dq_hi_oe_n, .i_pup_sleep(strap), .i_boot_octal(strap), .o_octal_mode, .o_rd_addr,
    .i_rd_data, .o_pgm_stb, .o_ers_stb, .o_wr_addr, .o_wr_data, .i_ecc_err, .i_ecc_addr,
    .o_ecc_count, .o_ecc_trap, .o_ecc_seen, .o_deep_sleep, .o_busy, .o_standby);
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (o_pgm_stb) pgm_n++;
    if (o_ers_stb) ers_n++;
    if (!o_so_oe_n) drove = 1'b1;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end
  task summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task head(input logic [7:0] op, input logic [23:0] ad, input int na, input int nl);
    // link edges keep clear of the core clock edge
    @(posedge i_ref_clk);
    #2;
    drove = 1'b0;
    host_u.open_tx;
    host_u.shift(8, op, rx);
    for (int i = na - 1; i >= 0; i--)
      host_u.shift(8, ad[8*i +: 8], rx);
    if (nl > 0)
      host_u.shift(nl, 8'h00, rx);
    chk("early_drive", drove, 1'b0);
  endtask : head
  task rd_bytes(input logic [23:0] ad, input int n);
    for (int k = 0; k < n; k++)
    begin
      host_u.shift(8, 8'h00, rx);
      chk("read_byte", rx, arr(ad + k));
    end
    host_u.close_tx;
    chk("released", o_so_oe_n, 1'b1);
  endtask : rd_bytes
  task status(input logic [7:0] c, input logic [7:0] exp);
    head(c, 24'h0, 0, 0);
    host_u.shift(8, 8'h00, rx);
    host_u.close_tx;
    chk("status", rx, exp);
  endtask : status
  task ecc_hit(input logic [23:0] ad);
    @(posedge i_ref_clk) #2 i_ecc_err = 1'b1;
    i_ecc_addr = ad;
    @(posedge i_ref_clk) #2 i_ecc_err = 1'b0;
  endtask : ecc_hit
  initial
  begin
    d = $urandom(84043);
    repeat (20) @(posedge i_ref_clk);
    #2 i_rst = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    #2;
    chk("upper_oe", o_dq_hi_oe_n, 6'h3F);
    chk("standby", o_standby, 1'b1);
    chk("octal", o_octal_mode, 1'b0);
    // plain and default latency fast reads; last one crosses the top address
    for (int t = 0; t < 4; t++)
    begin
      a = (t == 3) ? 24'hFFFFFE : $urandom;
      head(t[0] ? 8'h0B : 8'h03, a, 3, t[0] ? 8 : 0);
      rd_bytes(a, 3);
    end
    lat = 1 + $urandom % 15;
    head(8'h71, 24'h0, 0, 0);
    host_u.shift(8, lat[7:0], rx);
    host_u.close_tx;
    head(8'h0B, a, 3, lat);
    rd_bytes(a, 2);
    head(8'hC3, 24'h0, 0, 0);
    rd_bytes(24'h0, 0); // unknown command: checks only that line one is released after deselect
    status(8'h05, 8'h00);
    a = $urandom;
    d = $urandom;
    head(8'h02, a, 3, 0);
    host_u.shift(8, d, rx);
    host_u.close_tx;
    chk("pgm_count", pgm_n, 1);
    chk("pgm_addr", o_wr_addr, a);
    chk("pgm_data", o_wr_data, d);
    for (int i = 0; i < 100 && o_busy !== 1'b0; i++) @(posedge i_ref_clk);
    chk("pgm_done", pgm_n, 1);
    head(8'h36, a, 3, 0);
    host_u.close_tx;
    head(8'h02, a, 3, 0);
    host_u.shift(8, d, rx);
    host_u.close_tx;
    chk("locked_pgm", pgm_n, 1);
    status(8'h05, 8'h02);
    head(8'h39, a, 3, 0);
    host_u.close_tx;
    b = $urandom;
    head(8'hD8, b, 3, 0);
    host_u.close_tx;
    chk("ers_addr", o_wr_addr, b);
    // a program ends before one command byte is in, so refusals are tried during erase
    head(8'h03, b, 3, 0);
    host_u.shift(8, 8'h00, rx);
    host_u.close_tx;
    chk("busy_read", drove, 1'b0);
    status(8'h05, 8'h01);
    repeat (1500) @(posedge i_ref_clk);
    chk("ers_busy", o_busy, 1'b1);
    for (int i = 0; i < 700 && o_busy !== 1'b0; i++) @(posedge i_ref_clk);
    // standby is registered one clock behind busy
    repeat (2) @(posedge i_ref_clk);
    #2;
    chk("ers_count", ers_n, 1);
    chk("standby_back", o_standby, 1'b1);
    ecc_hit(a);
    ecc_hit(b);
    repeat (2) @(posedge i_ref_clk);
    chk("ecc_count", o_ecc_count, 8'h02);
    chk("ecc_trap", o_ecc_trap, b);
    status(8'h19, 8'h02);
    head(8'hB9, 24'h0, 0, 0);
    host_u.close_tx;
    chk("asleep", o_deep_sleep, 1'b1);
    head(8'h05, 24'h0, 0, 0);
    rd_bytes(24'h0, 0); // status while asleep: checks only that line one is released after deselect
    head(8'hAB, 24'h0, 0, 0);
    host_u.close_tx;
    chk("awake", o_deep_sleep, 1'b0);
    chk("ecc_clear", {o_ecc_seen, o_ecc_count}, 9'h000);
    head(8'h0B, b, 3, lat);
    rd_bytes(b, 2);
    // mid-run reset with both straps set: starts asleep with the serial port off
    strap = 1'b1;
    i_rst = 1'b1;
    repeat (20) @(posedge i_ref_clk);
    #2 i_rst = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    #2;
    chk("pup_sleep", o_deep_sleep, 1'b1);
    chk("octal_boot", o_octal_mode, 1'b1);
    head(8'h05, 24'h0, 0, 0);
    rd_bytes(24'h0, 0);
    summarize();
  end
endmodule : lsft_top_bench

// [testbench/lsft_top_properties.sv]
// port assertions of the serial flash front end
`timescale 1ns/1ns
module lsft_top_properties #(
  parameter int ADDR_BYTES = 3
) (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst, // reset
  input wire logic i_cs_n, // select
  input wire logic o_so, // line one
  input wire logic o_so_oe_n, // line one enable
  input wire logic [5:0] o_dq_hi_oe_n, // upper enables
  input wire logic o_octal_mode, // strap taken
  input wire logic o_pgm_stb, // program
  input wire logic o_ers_stb, // erase
  input wire logic o_busy, // busy
  input wire logic o_standby, // standby
  input wire logic o_deep_sleep, // sleep
  input wire logic i_ecc_err, // ecc event
  input wire logic [8*ADDR_BYTES-1:0] i_ecc_addr, // ecc address
  input wire logic [7:0] o_ecc_count, // counter
  input wire logic [8*ADDR_BYTES-1:0] o_ecc_trap, // trap
  input wire logic o_ecc_seen // flag
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // program runs about 50 clocks; a small window absorbs the strobe offset
  sequence s_pgm_run;
    o_busy [*8] ##[40:44] !o_busy;
  endsequence
  sequence s_wake_clr;
    ##[0:2] (o_ecc_count == 8'h00 && !o_ecc_seen && o_ecc_trap == '0);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_UPPER_HIZ: assert property (o_dq_hi_oe_n == 6'h3F)
    else $error("upper lines driven");
  AST_SO_REL: assert property ($rose(i_cs_n) |-> ##[0:6] o_so_oe_n)
    else $error("line one kept after deselect");
  AST_SO_QUIET: assert property (o_so_oe_n |-> !o_so)
    else $error("line one value while released");
  AST_PGM_TIME: assert property (o_pgm_stb |-> s_pgm_run)
    else $error("program time wrong");
  AST_PGM_ONE: assert property (o_pgm_stb |=> !o_pgm_stb && !o_ers_stb)
    else $error("program strobe too long");
  AST_ERS_BUSY: assert property (o_ers_stb |=> o_busy [*8])
    else $error("erase not busy");
  AST_BUSY_STBY: assert property ((o_busy || o_deep_sleep) |-> !o_standby)
    else $error("standby while working");
  AST_SLEEP_IN: assert property ($rose(o_deep_sleep) |-> !$past(o_busy))
    else $error("sleep entered while busy");
  AST_WAKE_CLR: assert property ($fell(o_deep_sleep) |-> s_wake_clr)
    else $error("ecc state kept on wake");
  AST_ECC_TRAP: assert property (i_ecc_err && !o_deep_sleep |=>
    o_ecc_trap == $past(i_ecc_addr) && o_ecc_seen)
    else $error("ecc trap not taken");
  AST_OCTAL_OFF: assert property (o_octal_mode |-> o_so_oe_n)
    else $error("serial port active in octal");
endmodule : lsft_top_properties
bind lsft_top lsft_top_properties #(.ADDR_BYTES(ADDR_BYTES)) chk_u (.i_ref_clk, .i_rst,
  .i_cs_n, .o_so, .o_so_oe_n, .o_dq_hi_oe_n, .o_octal_mode, .o_pgm_stb, .o_ers_stb,
  .o_busy, .o_standby, .o_deep_sleep, .i_ecc_err, .i_ecc_addr, .o_ecc_count,
  .o_ecc_trap, .o_ecc_seen);
